//--- rtl/output_mux_consts.vh
// Register offsets, field positions, reset values and codes for the output mux and status group.
`ifndef OUTPUT_MUX_CONSTS_VH
`define OUTPUT_MUX_CONSTS_VH

// Register indices on the internal register port.
`define OFS_EXACT_FREQ      5'h0C
`define OFS_PIN_SELECT      5'h0F
`define OFS_RESERVED_A      5'h10
`define OFS_RESERVED_B      5'h11
`define OFS_OUTPUT_LOCK     5'h12
`define OFS_SELF_TEST       5'h13

// Register widths.
`define DATA_W              24
`define CHAN_W              14
`define CTRL_W              10
`define RSV_A_W             9
`define RSV_B_W             19

// Reset values.
`define RST_EXACT_FREQ      14'h0000
`define RST_PIN_SELECT      10'h001
`define RST_RESERVED_A      9'h000
`define RST_RESERVED_B      19'h00000
`define RST_STATUS_BIT      1'h0
`define RST_SIGNATURE       16'h0000

// Fields of the pin select control register.
`define SEL_MSB             4
`define SEL_LSB             0
`define TEST_DATA_BIT       5
`define HOLD_MUX_BIT        6
`define KEEP_DRIVER_BIT     7
`define PULLUP_OFF_BIT      8
`define PULLDOWN_OFF_BIT    9

// Fields of the status and self-test registers.
`define STAT_GPO_BIT        0
`define STAT_LOCK_BIT       1
`define SIG_MSB             15
`define BUSY_BIT            16

// Lowest channel count that enables exact-frequency operation.
`define CHAN_MIN_ENABLE     14'h0002

`endif

//--- rtl/sdo_source_mux.v
// Thirty-two way selector that picks the general output source.
`timescale 1ns/10ps
`include "output_mux_consts.vh"

module sdo_source_mux (
    input  wire [31:0] src,     // Candidate source levels, one per code.
    input  wire [4:0]  sel,     // Source select code.
    output wire        y        // Selected level.
);

    // Plain index; every code has a bit, unused ones are tied low upstream.
    assign y = src[sel];

endmodule // sdo_source_mux

//--- rtl/sdo_pad_ctrl.v
// Serial data output pin control: automux, driver hold and pull stage gating.
`timescale 1ns/10ps
`include "output_mux_consts.vh"

module sdo_pad_ctrl (
    input  wire core_clk,         // System clock.
    input  wire nrst,             // Async reset, active low.
    input  wire gpo,              // Selected general output level.
    input  wire serial_sdo,       // Readback data from the serial port.
    input  wire serial_rd_active, // Serial port is shifting readback data.
    input  wire hold_output_mux,  // Blocks automux of the pin.
    input  wire keep_driver_on,   // Keeps the driver enabled.
    input  wire pullup_off,       // Disables the pull-up stage.
    input  wire pulldown_off,     // Disables the pull-down stage.
    output reg  sdo_o,            // Pin output level.
    output reg  sdo_oe,           // Pin output enable, high drives.
    output reg  pullup_on,        // Pull-up transistor on.
    output reg  pulldown_on       // Pull-down transistor on.
);

    wire automux;
    wire val;
    wire drive;
    wire pu;
    wire pd;

    // Idle pin carries the general output unless automux is held off.
    assign automux = ~hold_output_mux & ~serial_rd_active;
    assign val     = automux ? gpo : serial_sdo;
    assign drive   = serial_rd_active | keep_driver_on | automux;
    // A disabled stage cannot drive its level, so the pin floats then.
    assign pu      = drive & val & ~pullup_off;
    assign pd      = drive & ~val & ~pulldown_off;

    // Registered so the pad sees glitch-free levels.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sdo_o       <= 1'b0;
            sdo_oe      <= 1'b0;
            pullup_on   <= 1'b0;
            pulldown_on <= 1'b0;
        end else begin
            sdo_o       <= val;
            sdo_oe      <= pu | pd;
            pullup_on   <= pu;
            pulldown_on <= pd;
        end
    end

endmodule // sdo_pad_ctrl

//--- rtl/output_mux_status_regs.v
// Exact-frequency, output pin select and status register group.
`timescale 1ns/10ps
`include "output_mux_consts.vh"

// Functional notes
// - Counts 0 and 1 disable exact-frequency operation; 2 to 16383 are legal.
// - Enabled exact mode gives zero error at channel-spacing multiples.
// - Five-bit select picks the pin source; reset selects lock detect.
// - Codes 0-7: test bit, lock, trigger, window, ring, slip up/down, reserved.
// - Codes 8-15: reference, dividers, modulator clock, auxiliary clock and port.
// - Codes 26-29 unused; 30 output buffer enable; 31 soft reset.
// - Code zero drives the pin with the test-data bit at position 5.
// - Bit 6 stops automatic muxing of the pin with the general output.
// - Bit 7 keeps the serial port from disabling the pin driver.
// - Status register: general output in bit 0, lock detect in bit 1.
// - Self-test register: signature in bits 15:0, busy flag in bit 16.
// - Reserved register 0x10 reads zero; writes are ignored.
// - Reserved register 0x11 reads zero; writes are ignored.

// Design notes
// Writes land on the strobe edge; reads answer one edge later.
// The read word holds until the next read strobe.
// A read and a write to one index in one cycle return the old word.
// Status bits are registered copies, one edge behind their sources.
// Fast clocks on the selector are sampled and alias on readback.
// Pad controls trail a source change by two edges, a control-bit write by two, a select write by three.
// A disabled pull stage leaves that level undriven; the pin floats.
// Count and enable change on one edge for the modulator.
// Counts zero and one keep exact-frequency operation off.
// Software keeps the count integral, and zero outside exact mode.
// Reserved indices read constant zero and take no writes.
// Unused select codes read low, so a stray code gives a quiet pin.
// During a readback the serial port owns the pin level.
// Holding the driver on stops the line floating between transfers.
// All registers but reg_rdata load on every edge; reg_rdata loads only on a read strobe.
// Inputs are taken as synchronous to the core clock.
// Read data and its acknowledge both come from flip-flops.
// Nothing here resets except through nrst.

module output_mux_status_regs (
    // Clock and reset.
    input  wire        core_clk,         // System clock, 50 MHz.
    input  wire        nrst,             // Async reset, active low.

    // Register access port.
    input  wire [4:0]  reg_addr,         // Register index.
    input  wire [23:0] reg_wdata,        // Write data.
    input  wire        reg_wr,           // Write strobe.
    input  wire        reg_rd,           // Read strobe.
    output reg  [23:0] reg_rdata,        // Read data.
    output reg         reg_rd_ack,       // Read data valid pulse.

    // Candidate sources for the pin selector.
    input  wire        lock_detect,      // Lock detect level.
    input  wire        ld_trigger,       // Lock detect trigger.
    input  wire        ld_window,        // Lock detect window.
    input  wire        ring_osc_test,    // Ring oscillator test.
    input  wire        cycle_slip_up,    // Slip guard pull-up.
    input  wire        cycle_slip_dn,    // Slip guard pull-down.
    input  wire        ref_buf,          // Reference buffer.
    input  wire        ref_div_out,      // Reference divider.
    input  wire        fb_div_out,       // Feedback divider.
    input  wire        mod_clk,          // Modulator clock.
    input  wire        aux_clk,          // Auxiliary clock.
    input  wire        aux_sck,          // Aux serial clock.
    input  wire        aux_sen,          // Aux serial enable.
    input  wire        aux_sdo,          // Aux serial data out.
    input  wire        pd_down,          // Phase detector down.
    input  wire        pd_up,            // Phase detector up.
    input  wire        mod_clk_dly,      // Modulator clock delay.
    input  wire        mod_core_clk,     // Modulator core clock.
    input  wire        strobe_int,       // Integer autostrobe.
    input  wire        strobe_frac,      // Fractional autostrobe.
    input  wire        strobe_aux,       // Auxiliary autostrobe.
    input  wire        latch_en,         // Serial latch enable.
    input  wire        div_sync_rst,     // Divider sync reset.
    input  wire        seed_load,        // Seed load strobe.
    input  wire        sdo_buf_en,       // Output buffer enable.
    input  wire        soft_reset_n,     // Soft reset, active low.

    // Self-test results and serial readback state.
    input  wire [15:0] bist_signature,   // Self-test signature.
    input  wire        bist_busy,        // Self-test busy.
    input  wire        serial_sdo,       // Serial readback data.
    input  wire        serial_rd_active, // Readback in progress.

    // Modulator settings and pin controls.
    output reg  [13:0] channels_per_compare, // Channel count.
    output reg         exact_freq_en,    // Exact mode enabled.
    output reg         gpo_level,        // General output level.
    output wire        sdo_o,            // Pin level.
    output wire        sdo_oe,           // Pin output enable.
    output wire        pullup_on,        // Pull-up stage on.
    output wire        pulldown_on       // Pull-down stage on.
);

    // Pin select control register and the status and self-test captures.
    reg  [9:0]  pin_ctrl;
    reg         lock_q;
    reg  [15:0] sig_q;
    reg         busy_q;

    // Control register fields.
    wire [4:0]  sel;
    wire        test_data;
    wire        hold_output_mux;
    wire        keep_driver_on;
    wire        pullup_off;
    wire        pulldown_off;

    // Selector inputs and result.
    wire [31:0] src_vec;
    wire        mux_y;

    // Write decode and next values.
    wire        wr_chan;
    wire        wr_ctrl;
    wire [13:0] next_chan;
    wire [9:0]  next_ctrl;

    // Two or more channels is the only enabling range.
    // A function, so every user of the enable agrees on the bound.
    function exact_on;
        input [13:0] cnt;
        begin
            exact_on = (cnt >= `CHAN_MIN_ENABLE);
        end
    endfunction

    // True when a strobe targets the given index.
    // Shared by both write decodes so they cannot drift apart.
    function hit;
        input [4:0] addr;
        input [4:0] ofs;
        input       stb;
        begin
            hit = stb & (addr == ofs);
        end
    endfunction

    // Read word assembly; reserved and unmapped bits read zero.
    // Each branch fills only its register's width; the rest stays zero.
    function [23:0] rd_word;
        input [4:0]  addr;
        input [13:0] chan;
        input [9:0]  ctrl;
        input        gpo;
        input        lock;
        input [15:0] sig;
        input        busy;
        begin
            rd_word = 24'h000000;
            // Writable registers return their stored values.
            if (addr == `OFS_EXACT_FREQ) begin
                rd_word[13:0] = chan;
            end else if (addr == `OFS_PIN_SELECT) begin
                rd_word[9:0] = ctrl;
            end else if (addr == `OFS_RESERVED_A) begin
                // Constant zero; no storage stands behind it.
                rd_word[8:0] = `RST_RESERVED_A;
            end else if (addr == `OFS_RESERVED_B) begin
                rd_word[18:0] = `RST_RESERVED_B;
            end else if (addr == `OFS_OUTPUT_LOCK) begin
                // Copies taken one edge earlier, never raw inputs.
                rd_word[`STAT_GPO_BIT] = gpo;
                rd_word[`STAT_LOCK_BIT] = lock;
            end else if (addr == `OFS_SELF_TEST) begin
                // Busy flag sits just above the signature.
                rd_word[`SIG_MSB:0] = sig;
                rd_word[`BUSY_BIT] = busy;
            end
        end
    endfunction

    // Field views of the control register.
    // Decoded once here so every consumer sees the same bit.
    assign sel             = pin_ctrl[`SEL_MSB:`SEL_LSB];
    assign test_data       = pin_ctrl[`TEST_DATA_BIT];
    assign hold_output_mux = pin_ctrl[`HOLD_MUX_BIT];
    assign keep_driver_on  = pin_ctrl[`KEEP_DRIVER_BIT];
    assign pullup_off      = pin_ctrl[`PULLUP_OFF_BIT];
    assign pulldown_off    = pin_ctrl[`PULLDOWN_OFF_BIT];

    // Only the two writable registers decode writes; reserved ones ignore them.
    // A write elsewhere leaves both registers as they are.
    assign wr_chan = hit(reg_addr, `OFS_EXACT_FREQ, reg_wr);
    assign wr_ctrl = hit(reg_addr, `OFS_PIN_SELECT, reg_wr);
    assign next_chan = wr_chan ? reg_wdata[13:0] : channels_per_compare;
    assign next_ctrl = wr_ctrl ? reg_wdata[9:0] : pin_ctrl;

    // Channel count register; software keeps the value integral and mode-correct.
    // Bits above the field are dropped on write.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            channels_per_compare <= `RST_EXACT_FREQ;
        end else begin
            channels_per_compare <= next_chan;
        end
    end

    // Exact-mode enable follows the stored count; the modulator uses both.
    // Taken from the next value so count and enable never disagree.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            exact_freq_en <= 1'b0;
        end else begin
            exact_freq_en <= exact_on(next_chan);
        end
    end

    // Pin select control register.
    // Reset selects lock detect with both pull stages enabled.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_ctrl <= `RST_PIN_SELECT;
        end else begin
            pin_ctrl <= next_ctrl;
        end
    end

    // Source vector by select code.
    // Each code owns one bit; gaps are tied low so the selector stays plain.
    assign src_vec[0]  = test_data;
    assign src_vec[1]  = lock_detect;
    assign src_vec[2]  = ld_trigger;
    assign src_vec[3]  = ld_window;
    assign src_vec[4]  = ring_osc_test;
    assign src_vec[5]  = cycle_slip_up;
    assign src_vec[6]  = cycle_slip_dn;
    assign src_vec[7]  = 1'b0;

    // Reference path, dividers and auxiliary port.
    assign src_vec[8]  = ref_buf;
    assign src_vec[9]  = ref_div_out;
    assign src_vec[10] = fb_div_out;
    assign src_vec[11] = mod_clk;
    assign src_vec[12] = aux_clk;
    assign src_vec[13] = aux_sck;
    assign src_vec[14] = aux_sen;
    assign src_vec[15] = aux_sdo;

    // Detector, modulator clocks, strobes and seed load.
    assign src_vec[16] = pd_down;
    assign src_vec[17] = pd_up;
    assign src_vec[18] = mod_clk_dly;
    assign src_vec[19] = mod_core_clk;
    assign src_vec[20] = strobe_int;
    assign src_vec[21] = strobe_frac;
    assign src_vec[22] = strobe_aux;
    assign src_vec[23] = latch_en;
    assign src_vec[24] = div_sync_rst;
    assign src_vec[25] = seed_load;

    // Unused codes read low; the top two carry device state.
    assign src_vec[26] = 1'b0;
    assign src_vec[27] = 1'b0;
    assign src_vec[28] = 1'b0;
    assign src_vec[29] = 1'b0;
    assign src_vec[30] = sdo_buf_en;
    assign src_vec[31] = soft_reset_n;

    // Selector for the general output.
    // Split out so the pad path and the readback share one level.
    sdo_source_mux u_sel (
        .src (src_vec),
        .sel (sel),
        .y   (mux_y)
    );

    // Fast clocks routed here are sampled, so only slow events show faithfully.
    // Registering keeps combinational glitches off the pad path.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gpo_level <= `RST_STATUS_BIT;
        end else begin
            gpo_level <= mux_y;
        end
    end

    // Lock detect capture for the status register.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_q <= `RST_STATUS_BIT;
        end else begin
            lock_q <= lock_detect;
        end
    end

    // Self-test captures; the extra edge keeps reads free of mid-cycle changes.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sig_q  <= `RST_SIGNATURE;
            busy_q <= `RST_STATUS_BIT;
        end else begin
            sig_q  <= bist_signature;
            busy_q <= bist_busy;
        end
    end

    // Acknowledge pulse follows each read strobe by one edge.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rd_ack <= 1'b0;
        end else begin
            reg_rd_ack <= reg_rd;
        end
    end

    // Read port answers one cycle after the strobe and holds the word.
    // Holding the word lets a slow host sample it after the pulse.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 24'h000000;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rd_word(reg_addr, channels_per_compare, pin_ctrl,
                                     gpo_level, lock_q, sig_q, busy_q);
            end
        end
    end

    // Pin driver with automux, driver hold and pull stage gating.
    // The serial port tells it when a readback owns the pin.
    sdo_pad_ctrl u_pad (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .gpo              (gpo_level),
        .serial_sdo       (serial_sdo),
        .serial_rd_active (serial_rd_active),
        .hold_output_mux  (hold_output_mux),
        .keep_driver_on   (keep_driver_on),
        .pullup_off       (pullup_off),
        .pulldown_off     (pulldown_off),
        .sdo_o            (sdo_o),
        .sdo_oe           (sdo_oe),
        .pullup_on        (pullup_on),
        .pulldown_on      (pulldown_on)
    );

endmodule // output_mux_status_regs

//--- bench/output_mux_status_chk.sv
// Concurrent checks on the register port and pin controls of the output mux group.
`timescale 1ns/10ps
`include "output_mux_consts.vh"
module output_mux_status_chk (
    input wire logic        core_clk,             // Clock.
    input wire logic        nrst,                 // Async reset, active low.
    input wire logic [4:0]  reg_addr,             // Register index.
    input wire logic [23:0] reg_wdata,            // Write data.
    input wire logic        reg_wr,               // Write strobe.
    input wire logic        reg_rd,               // Read strobe.
    input wire logic [23:0] reg_rdata,            // Read data.
    input wire logic        reg_rd_ack,           // Read valid pulse.
    input wire logic [15:0] bist_signature,       // Self-test signature.
    input wire logic        bist_busy,            // Self-test busy.
    input wire logic [13:0] channels_per_compare, // Channel count.
    input wire logic        exact_freq_en,        // Exact mode enabled.
    input wire logic        gpo_level,            // General output level.
    input wire logic        sdo_oe,               // Pin output enable.
    input wire logic        pullup_on,            // Pull-up stage on.
    input wire logic        pulldown_on           // Pull-down stage on.
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Accesses are built from these request shapes.
    sequence s_read(logic [4:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_write(logic [4:0] a);
        reg_wr && reg_addr == a;
    endsequence
    property p_ack; reg_rd |=> reg_rd_ack; endproperty
    a_ack: assert property (p_ack) else $error("read not acknowledged");
    property p_noack; !reg_rd |=> !reg_rd_ack; endproperty
    a_noack: assert property (p_noack) else $error("spurious read acknowledge");
    property p_count; s_write(`OFS_EXACT_FREQ) |=> channels_per_compare == $past(reg_wdata[13:0]); endproperty
    a_count: assert property (p_count) else $error("channel count not stored");
    property p_en; s_write(`OFS_EXACT_FREQ) |=> exact_freq_en == ($past(reg_wdata[13:0]) >= 14'h0002); endproperty
    a_en: assert property (p_en) else $error("exact enable wrong");
    property p_rsv; reg_rd && (reg_addr == `OFS_RESERVED_A || reg_addr == `OFS_RESERVED_B) |=> reg_rdata == 24'h000000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
    property p_bist;
        s_read(`OFS_SELF_TEST) ##0 ($stable(bist_signature) && $stable(bist_busy))
            |=> reg_rdata == {7'h00, $past(bist_busy), $past(bist_signature)};
    endproperty
    a_bist: assert property (p_bist) else $error("self-test read wrong");
    property p_status; s_read(`OFS_OUTPUT_LOCK) |=> reg_rdata[0] == $past(gpo_level); endproperty
    a_status: assert property (p_status) else $error("status general output bit wrong");
    property p_oe; sdo_oe == (pullup_on || pulldown_on); endproperty
    a_oe: assert property (p_oe) else $error("pin enable disagrees with stages");
    property p_pulls; !(pullup_on && pulldown_on); endproperty
    a_pulls: assert property (p_pulls) else $error("both pull stages on");
endmodule // output_mux_status_chk

bind output_mux_status_regs output_mux_status_chk chk_i (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack),
    .bist_signature(bist_signature), .bist_busy(bist_busy), .channels_per_compare(channels_per_compare),
    .exact_freq_en(exact_freq_en), .gpo_level(gpo_level), .sdo_oe(sdo_oe), .pullup_on(pullup_on),
    .pulldown_on(pulldown_on));

//--- bench/host_model.sv
// Host controller model that drives the register port at the falling clock edge.
`timescale 1ns/10ps
module host_model (
    input  wire logic        core_clk,   // Clock.
    output logic [4:0]       reg_addr,   // Register index.
    output logic [23:0]      reg_wdata,  // Write data.
    output logic             reg_wr,     // Write strobe.
    output logic             reg_rd,     // Read strobe.
    input  wire logic [23:0] reg_rdata,  // Read data.
    input  wire logic        reg_rd_ack  // Read valid pulse.
);
    // Idle port with no request pending.
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Counts written are whole; zero is written whenever exact mode is left.
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // Released data must not look like a held value.
        @(negedge core_clk); // One idle edge keeps back-to-back strobes apart.
    endtask
    // A missing acknowledge returns unknowns so the caller sees a mismatch.
    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rd_ack ? reg_rdata : 24'hXXXXXX;
        @(negedge core_clk);
    endtask
endmodule // host_model

//--- bench/output_mux_status_regs_tb.sv
// Self-checking testbench for the output mux and status register group.
`timescale 1ns/10ps
`include "output_mux_consts.vh"
module output_mux_status_regs_tb;
    localparam logic [31:0] LIVE = 32'hC3FFFF7F; // Codes that route a real source.
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic [25:0] src      = 26'h0000000;
    logic [15:0] sig      = 16'h0000;
    logic        busy     = 1'b0;
    logic        ser_sdo  = 1'b0;
    logic        ser_act  = 1'b0;
    logic [23:0] rv;
    wire  [4:0]  reg_addr;
    wire  [23:0] reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, reg_rd_ack, en, gpo, sdo_o, sdo_oe, pu, pd;
    wire  [13:0] chans;
    int          errors = 0;
    int          total_checks = 0;
    // Pin rows: control word, readback active, readback bit, then {level, enable, pull-up, pull-down}.
    logic [15:0] rows [7] = '{{10'h001, 2'b00, 4'hE}, {10'h041, 2'b00, 4'h0}, {10'h0C1, 2'b00, 4'h5},
        {10'h2C1, 2'b00, 4'h0}, {10'h101, 2'b00, 4'h8}, {10'h001, 2'b11, 4'hE}, {10'h001, 2'b10, 4'h5}};
    logic [13:0] cnts [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3FFF};
    logic [4:0]  dead [4] = '{`OFS_RESERVED_A, `OFS_RESERVED_B, `OFS_SELF_TEST, 5'h00};

    // Free-running clock.
    always #10 core_clk = ~core_clk;

    output_mux_status_regs output_mux_status_regs_i (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .lock_detect(src[0]), .ld_trigger(src[1]),
        .ld_window(src[2]), .ring_osc_test(src[3]), .cycle_slip_up(src[4]), .cycle_slip_dn(src[5]),
        .ref_buf(src[6]), .ref_div_out(src[7]), .fb_div_out(src[8]), .mod_clk(src[9]), .aux_clk(src[10]),
        .aux_sck(src[11]), .aux_sen(src[12]), .aux_sdo(src[13]), .pd_down(src[14]), .pd_up(src[15]),
        .mod_clk_dly(src[16]), .mod_core_clk(src[17]), .strobe_int(src[18]), .strobe_frac(src[19]),
        .strobe_aux(src[20]), .latch_en(src[21]), .div_sync_rst(src[22]), .seed_load(src[23]),
        .sdo_buf_en(src[24]), .soft_reset_n(src[25]), .bist_signature(sig), .bist_busy(busy),
        .serial_sdo(ser_sdo), .serial_rd_active(ser_act), .channels_per_compare(chans), .exact_freq_en(en),
        .gpo_level(gpo), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .pullup_on(pu), .pulldown_on(pd));

    host_model host_model_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack));

    // Maps a select code to its bit in the source vector; gaps at 7 and 26 to 29.
    function automatic int idx(input int c);
        if (c < 7) return c - 1;
        if (c < 26) return c - 2;
        return c - 6;
    endfunction

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence: reset values, pin rows, every select code, then the awkward register cases.
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) nrst = 1'b1;
        host_model_i.rd(`OFS_EXACT_FREQ, rv); check("count reset", rv, 24'h000000);
        host_model_i.rd(`OFS_PIN_SELECT, rv); check("control reset", rv, 24'h000001);
        host_model_i.rd(`OFS_OUTPUT_LOCK, rv); check("status reset", rv, 24'h000000);
        host_model_i.rd(`OFS_SELF_TEST, rv); check("self-test reset", rv, 24'h000000);
        src = 26'h0000001;
        foreach (rows[i]) begin
            ser_act = rows[i][5];
            ser_sdo = rows[i][4];
            host_model_i.wr(`OFS_PIN_SELECT, {14'h0000, rows[i][15:6]});
            repeat (3) @(negedge core_clk);
            check("pin", {20'h00000, sdo_o, sdo_oe, pu, pd}, {20'h00000, rows[i][3:0]});
        end
        ser_act = 1'b0;
        for (int c = 0; c < 32; c++) begin
            for (int p = 0; p < 2; p++) begin
                src = ((LIVE[c] && c != 0) ? (26'h0000001 << idx(c)) : 26'h0000000) ^ {26{p[0]}};
                host_model_i.wr(`OFS_PIN_SELECT, {18'h00000, ~p[0], c[4:0]});
                @(negedge core_clk);
                host_model_i.rd(`OFS_OUTPUT_LOCK, rv);
                check("selected source", {23'h000000, rv[0]}, {23'h000000, LIVE[c] & ~p[0]});
            end
        end
        foreach (cnts[i]) begin
            host_model_i.wr(`OFS_EXACT_FREQ, {10'h3FF, cnts[i]});
            check("exact enable", {23'h000000, en}, {23'h000000, cnts[i] >= 14'h0002});
            host_model_i.rd(`OFS_EXACT_FREQ, rv); check("count", rv, {10'h000, cnts[i]});
        end
        host_model_i.wr(`OFS_EXACT_FREQ, 24'h000000);
        foreach (dead[i]) begin
            host_model_i.wr(dead[i], 24'hFFFFFF);
            host_model_i.rd(dead[i], rv); check("read-only place", rv, 24'h000000);
        end
        check("count kept", {10'h000, chans}, 24'h000000);
        sig = 16'hA5C3;
        busy = 1'b1;
        repeat (2) @(negedge core_clk);
        host_model_i.rd(`OFS_SELF_TEST, rv); check("self-test", rv, 24'h01A5C3);
        src = 26'h0000001;
        host_model_i.wr(`OFS_PIN_SELECT, 24'h000001);
        @(negedge core_clk);
        host_model_i.rd(`OFS_OUTPUT_LOCK, rv); check("status", rv, 24'h000003);
        close_out();
    end
endmodule // output_mux_status_regs_tb
